// [pkg/dep_regs.vh]
// Purpose: register indices, field positions, reset values and masks of the digital enable and pad block
// Assumes: byte address is four times the register index
// Notes: definitions only
`ifndef DEP_REGS_VH
`define DEP_REGS_VH

`define DEP_IDX_PAD_DRIVE 15'h4030
`define DEP_IDX_MASTER_CLOCK_OUT_PAD_PAD 15'h4031
`define DEP_IDX_DEJITTER 15'h4032
`define DEP_IDX_EN_MAIN 15'h4080
`define DEP_IDX_EN_AUX 15'h4081
`define DEP_IDX_STATUS 15'h4082

`define DEP_RST_PAD_DRIVE 8'h00
`define DEP_RST_MASTER_CLOCK_OUT_PAD_PAD 8'h01
`define DEP_RST_DEJITTER 8'h05
`define DEP_RST_EN_MAIN 8'h00
`define DEP_RST_EN_AUX 8'h0c

`define DEP_MASK_PAD_DRIVE 8'h0f
`define DEP_MASK_MASTER_CLOCK_OUT_PAD_PAD 8'h07
`define DEP_MASK_DEJITTER 8'hff
`define DEP_MASK_EN_MAIN 8'hff
`define DEP_MASK_EN_AUX 8'h0e

`define DEP_PAD_DATA_IN 3
`define DEP_PAD_LATCH 2
`define DEP_PAD_CLOCK 1
`define DEP_PAD_DATA_OUT 0

`define DEP_MASTER_CLOCK_OUT_PAD_DRIVE 2
`define DEP_MASTER_CLOCK_OUT_PAD_PULLUP 1
`define DEP_MASTER_CLOCK_OUT_PAD_PULLDOWN 0

`define DEP_MAIN_ADC 7
`define DEP_MAIN_MEMCTL 6
`define DEP_MAIN_CDT 5
`define DEP_MAIN_SPORT 4
`define DEP_MAIN_OUT_ROUTE 3
`define DEP_MAIN_IN_ROUTE 2
`define DEP_MAIN_CLKGEN 1
`define DEP_MAIN_CORE 0

`define DEP_AUX_PRECHARGE 3
`define DEP_AUX_ZERO_CROSS 2
`define DEP_AUX_DMIC 1

`define DEP_ST_FAILED 0
`define DEP_ST_BYPASS 1
`define DEP_ST_MEM_OK 2

`define DEP_RESP_OKAY 2'b00
`define DEP_RESP_SLVERR 2'b10

`endif

// [src/dep_top.v]
// Purpose: digital enable, dejitter window and pad configuration registers behind an AXI4-Lite slave
// Assumes: single clock clk_sys at 100 MHz, asynchronous active-low reset
// Notes: registers are 8 bits wide in the low byte of each aligned word
`timescale 1ns/100ps
`default_nettype none
`include "dep_regs.vh"

module dep_top (
   input wire clk_sys,
   input wire resetn,
   // axi4-lite slave
   input wire [16:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [16:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // control-port memory request
   input wire ctl_mem_req,
   output reg ctl_mem_grant,
   output reg ctl_mem_refused,
   // slave-mode serial frame strobe from a pin
   input wire sport_frame_pin,
   output reg sample_pass,
   // subsystem enables
   output reg adc_enable,
   output reg dmic_enable,
   output reg mem_access_enable,
   output reg sport_enable,
   output reg record_route_enable,
   output reg playback_route_enable,
   output reg clk_gen_enable,
   output reg core_run,
   output reg precharge_enable,
   output reg zero_cross_enable,
   output reg dejitter_bypass,
   output reg dejitter_reset,
   output reg [7:0] dejitter_window_size,
   // pad controls
   output reg control_data_in_pad_drive,
   output reg control_latch_pad_drive,
   output reg control_clock_pad_drive,
   output reg control_data_out_pad_drive,
   output reg master_clock_out_pad_drive,
   output reg master_clock_out_pad_pullup,
   output reg master_clock_out_pad_pulldown
);

   reg [7:0] ctrl_port_pad_drive;
   reg [7:0] master_clk_out_pad;
   reg [7:0] dejitter_window;
   reg [7:0] digital_enable_main;
   reg [7:0] digital_enable_aux;
   reg dejitter_failed;

   reg aw_held;
   reg [16:0] aw_addr;
   reg w_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   // 7 = no register at this address
   function [2:0] dep_decode;
      input [16:0] addr;
      begin
         case (addr[16:2])
            `DEP_IDX_PAD_DRIVE: dep_decode = 3'h0;
            `DEP_IDX_MASTER_CLOCK_OUT_PAD_PAD: dep_decode = 3'h1;
            `DEP_IDX_DEJITTER: dep_decode = 3'h2;
            `DEP_IDX_EN_MAIN: dep_decode = 3'h3;
            `DEP_IDX_EN_AUX: dep_decode = 3'h4;
            `DEP_IDX_STATUS: dep_decode = 3'h5;
            default: dep_decode = 3'h7;
         endcase
      end
   endfunction

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   wire do_write = aw_held & w_held & ~s_axi_bvalid;
   wire [2:0] wsel = dep_decode(aw_addr);
   wire wbyte = do_write & w_strb[0];
   wire [7:0] wd = w_data[7:0];
   wire win_zero_write = wbyte & (wsel == 3'h2) & (wd == 8'h00);

   // write channel capture, address and data in either order
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         aw_held <= 1'b0;
         aw_addr <= 17'h00000;
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DEP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // status is read-only, so a write to it is an error like an unmapped one
            s_axi_bresp <= (wsel < 3'h5) ? `DEP_RESP_OKAY : `DEP_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register bank; the upper three lanes hold nothing, so only lane 0 matters
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_port_pad_drive <= `DEP_RST_PAD_DRIVE;
         master_clk_out_pad <= `DEP_RST_MASTER_CLOCK_OUT_PAD_PAD;
         dejitter_window <= `DEP_RST_DEJITTER;
         digital_enable_main <= `DEP_RST_EN_MAIN;
         digital_enable_aux <= `DEP_RST_EN_AUX;
      end else if (wbyte) begin
         case (wsel)
            3'h0: ctrl_port_pad_drive <= wd & `DEP_MASK_PAD_DRIVE;
            3'h1: master_clk_out_pad <= wd & `DEP_MASK_MASTER_CLOCK_OUT_PAD_PAD;
            3'h2: dejitter_window <= wd & `DEP_MASK_DEJITTER;
            3'h3: digital_enable_main <= wd & `DEP_MASK_EN_MAIN;
            3'h4: digital_enable_aux <= wd & `DEP_MASK_EN_AUX;
            default: ctrl_port_pad_drive <= ctrl_port_pad_drive;
         endcase
      end
   end

   wire [7:0] status_word = {5'h00, mem_access_enable, dejitter_bypass, dejitter_failed};
   reg [7:0] next_rbyte;
   reg [1:0] next_rresp;

   always @* begin
      next_rresp = `DEP_RESP_OKAY;
      case (dep_decode(s_axi_araddr))
         3'h0: next_rbyte = ctrl_port_pad_drive;
         3'h1: next_rbyte = master_clk_out_pad;
         3'h2: next_rbyte = dejitter_window;
         3'h3: next_rbyte = digital_enable_main;
         3'h4: next_rbyte = digital_enable_aux;
         3'h5: next_rbyte = status_word;
         default: begin
            next_rbyte = 8'h00;
            next_rresp = `DEP_RESP_SLVERR;
         end
      endcase
   end

   // read channel: answer on the same edge that takes the address
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DEP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, next_rbyte};
         s_axi_rresp <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // decoded enables; registered so the outputs are glitch-free
   wire m_adc = digital_enable_main[`DEP_MAIN_ADC];
   wire m_mem = digital_enable_main[`DEP_MAIN_MEMCTL];
   wire m_core = digital_enable_main[`DEP_MAIN_CORE];
   wire m_clk = digital_enable_main[`DEP_MAIN_CLKGEN];
   wire mem_ok = m_mem & m_core;
   wire run_adc = m_adc & m_mem;
   wire run_sport = digital_enable_main[`DEP_MAIN_CDT] & digital_enable_main[`DEP_MAIN_SPORT];
   wire run_core = m_core & m_mem;

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         adc_enable <= 1'b0;
         dmic_enable <= 1'b0;
         mem_access_enable <= 1'b0;
         sport_enable <= 1'b0;
         record_route_enable <= 1'b0;
         playback_route_enable <= 1'b0;
         clk_gen_enable <= 1'b0;
         core_run <= 1'b0;
         precharge_enable <= 1'b1;
         zero_cross_enable <= 1'b1;
         dejitter_bypass <= 1'b0;
         dejitter_window_size <= `DEP_RST_DEJITTER;
         control_data_in_pad_drive <= 1'b0;
         control_latch_pad_drive <= 1'b0;
         control_clock_pad_drive <= 1'b0;
         control_data_out_pad_drive <= 1'b0;
         master_clock_out_pad_drive <= 1'b0;
         master_clock_out_pad_pullup <= 1'b0;
         master_clock_out_pad_pulldown <= 1'b1;
      end else begin
         adc_enable <= run_adc;
         dmic_enable <= run_adc & digital_enable_aux[`DEP_AUX_DMIC];
         mem_access_enable <= mem_ok;
         sport_enable <= run_sport;
         record_route_enable <= digital_enable_main[`DEP_MAIN_OUT_ROUTE];
         playback_route_enable <= digital_enable_main[`DEP_MAIN_IN_ROUTE];
         clk_gen_enable <= m_clk;
         core_run <= run_core;
         precharge_enable <= digital_enable_aux[`DEP_AUX_PRECHARGE];
         zero_cross_enable <= digital_enable_aux[`DEP_AUX_ZERO_CROSS];
         dejitter_bypass <= (dejitter_window == 8'h00);
         dejitter_window_size <= dejitter_window;
         control_data_in_pad_drive <= ctrl_port_pad_drive[`DEP_PAD_DATA_IN];
         control_latch_pad_drive <= ctrl_port_pad_drive[`DEP_PAD_LATCH];
         control_clock_pad_drive <= ctrl_port_pad_drive[`DEP_PAD_CLOCK];
         control_data_out_pad_drive <= ctrl_port_pad_drive[`DEP_PAD_DATA_OUT];
         master_clock_out_pad_drive <= master_clk_out_pad[`DEP_MASTER_CLOCK_OUT_PAD_DRIVE];
         master_clock_out_pad_pullup <= master_clk_out_pad[`DEP_MASTER_CLOCK_OUT_PAD_PULLUP];
         master_clock_out_pad_pulldown <= master_clk_out_pad[`DEP_MASTER_CLOCK_OUT_PAD_PULLDOWN];
      end
   end

   // control-port memory requests are answered the next cycle
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctl_mem_grant <= 1'b0;
         ctl_mem_refused <= 1'b0;
      end else begin
         ctl_mem_grant <= ctl_mem_req & mem_ok;
         ctl_mem_refused <= ctl_mem_req & ~mem_ok;
      end
   end

   // dejitter failure: a running subsystem dropped out while the circuit was active
   reg [2:0] run_prev;
   wire [2:0] run_now = {run_adc, run_sport, run_core};
   wire run_fall = |(run_prev & ~run_now);

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         run_prev <= 3'h0;
         dejitter_failed <= 1'b0;
         dejitter_reset <= 1'b0;
      end else begin
         run_prev <= run_now;
         dejitter_reset <= win_zero_write;
         // a fall in the same cycle as the reinitialising write still counts
         if (run_fall && dejitter_window != 8'h00)
            dejitter_failed <= 1'b1;
         else if (win_zero_write)
            dejitter_failed <= 1'b0;
      end
   end

   // frame strobe synchroniser; a change counts once stages two and three agree
   reg fr_s1;
   reg fr_s2;
   reg fr_s3;
   reg fr_level;
   reg [7:0] guard;
   wire fr_rise = fr_s2 & fr_s3 & ~fr_level;

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fr_s1 <= 1'b0;
         fr_s2 <= 1'b0;
         fr_s3 <= 1'b0;
         fr_level <= 1'b0;
         guard <= 8'h00;
         sample_pass <= 1'b0;
      end else begin
         fr_s1 <= sport_frame_pin;
         fr_s2 <= fr_s1;
         fr_s3 <= fr_s2;
         if (fr_s2 == fr_s3)
            fr_level <= fr_s3;
         sample_pass <= 1'b0;
         if (win_zero_write) begin
            guard <= 8'h00;
         end else if (fr_rise && sport_enable && !dejitter_failed) begin
            // inside the window a second edge is jitter, not a new sample
            if (dejitter_window == 8'h00 || guard == 8'h00) begin
               sample_pass <= 1'b1;
               guard <= dejitter_window;
            end else begin
               guard <= guard - 8'h01;
            end
         end else if (guard != 8'h00) begin
            guard <= guard - 8'h01;
         end
      end
   end

endmodule // dep_top
`default_nettype wire

// [verif/dep_monitor.sv]
// Purpose: port-level assertions for dep_top
// Assumes: one clock, asynchronous active-low reset
// Notes: sees only top ports, attached by bind
`timescale 1ns/100ps
`default_nettype none
module dep_monitor (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ctl_mem_req,
   input wire logic ctl_mem_grant,
   input wire logic ctl_mem_refused,
   input wire logic sample_pass,
   input wire logic adc_enable,
   input wire logic dmic_enable,
   input wire logic mem_access_enable,
   input wire logic sport_enable,
   input wire logic clk_gen_enable,
   input wire logic core_run,
   input wire logic precharge_enable,
   input wire logic zero_cross_enable,
   input wire logic dejitter_bypass,
   input wire logic dejitter_reset,
   input wire logic [7:0] dejitter_window_size,
   input wire logic master_clock_out_pad_pulldown
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   a_rst_values: assert property ($rose(resetn) |-> precharge_enable && zero_cross_enable
      && master_clock_out_pad_pulldown && dejitter_window_size == 8'h05 && !core_run && !adc_enable
      && !sport_enable && !clk_gen_enable) else $error("reset values wrong");
   a_mem_core_pair: assert property (mem_access_enable == core_run) else $error("memory and core differ");
   a_dmic_needs_adc: assert property (dmic_enable |-> adc_enable) else $error("mic without adc engine");
   a_bypass_window: assert property (dejitter_bypass == (dejitter_window_size == 8'h00))
      else $error("bypass not tied to zero window");
   a_reset_pulse: assert property (dejitter_reset |=> !dejitter_reset && dejitter_bypass)
      else $error("dejitter reset not a single pulse");
   a_mem_answer: assert property (ctl_mem_req |=> ctl_mem_grant != ctl_mem_refused)
      else $error("memory request unanswered");
   a_mem_quiet: assert property (!ctl_mem_req |=> !ctl_mem_grant && !ctl_mem_refused)
      else $error("memory answer without request");
   a_grant_cause: assert property (ctl_mem_grant |-> mem_access_enable || $past(mem_access_enable))
      else $error("grant while memory blocked");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_pass_gate: assert property (sample_pass |-> (sport_enable || $past(sport_enable)) ##1 !sample_pass)
      else $error("sample pass without serial port");
endmodule // dep_monitor
bind dep_top dep_monitor dep_monitor_inst (.clk_sys(clk_sys), .resetn(resetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ctl_mem_req(ctl_mem_req),
   .ctl_mem_grant(ctl_mem_grant), .ctl_mem_refused(ctl_mem_refused), .sample_pass(sample_pass),
   .adc_enable(adc_enable), .dmic_enable(dmic_enable), .mem_access_enable(mem_access_enable),
   .sport_enable(sport_enable), .clk_gen_enable(clk_gen_enable), .core_run(core_run),
   .precharge_enable(precharge_enable), .zero_cross_enable(zero_cross_enable), .dejitter_bypass(dejitter_bypass),
   .dejitter_reset(dejitter_reset), .dejitter_window_size(dejitter_window_size),
   .master_clock_out_pad_pulldown(master_clock_out_pad_pulldown));
`default_nettype wire

// [verif/dep_top_tb.sv]
// Purpose: self-checking bench for dep_top
// Assumes: byte address is four times the register index
// Notes: fixed seed; random register traffic plus frame corner cases
`timescale 1ns/100ps
`default_nettype none
`include "dep_regs.vh"
`define CHK(g,e) begin checks++; if ((g)!==(e)) begin err_count++; $display("[ERR] %0t %h %h",$time,g,e); end end
module dep_top_tb;
   logic clk_sys=0, resetn=0, awv=0, wv=0, bry=0, arv=0, rry=0, req=0, pin=0;
   logic [16:0] awa=0, ara=0;
   logic [31:0] wd=0;
   logic [3:0] ws=0;
   logic [14:0] ia [5];
   logic [7:0] ma [5], ra [5], sh [5];
   int seed=43, k, i, cyc=0, pc=0, err_count=0, checks=0;
   wire [25:0] ov;
   wire [31:0] rdata;
   wire [1:0] bresp, rresp;
   wire awr, wrd, bv, arr, rv, gnt, rf, spass, djr;
   dep_top dep_top_inst (.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .ctl_mem_req(req), .ctl_mem_grant(gnt), .ctl_mem_refused(rf),
      .sport_frame_pin(pin), .sample_pass(spass), .adc_enable(ov[25]), .dmic_enable(ov[24]),
      .mem_access_enable(ov[23]), .sport_enable(ov[22]), .record_route_enable(ov[21]),
      .playback_route_enable(ov[20]), .clk_gen_enable(ov[19]), .core_run(ov[18]), .precharge_enable(ov[17]),
      .zero_cross_enable(ov[16]), .dejitter_bypass(ov[15]), .dejitter_reset(djr), .dejitter_window_size(ov[14:7]),
      .control_data_in_pad_drive(ov[6]), .control_latch_pad_drive(ov[5]), .control_clock_pad_drive(ov[4]),
      .control_data_out_pad_drive(ov[3]), .master_clock_out_pad_drive(ov[2]),
      .master_clock_out_pad_pullup(ov[1]), .master_clock_out_pad_pulldown(ov[0]));
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      pc <= pc + (spass === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         close_out;
      end
   end
   function automatic [25:0] oexp(input [7:0] p, o, j, m, a);
      oexp = {m[7]&m[6], m[7]&m[6]&a[1], m[6]&m[0], m[5]&m[4], m[3:1], m[0]&m[6], a[3:2], j == 8'h00, j, p[3:0], o[2:0]};
   endfunction
   task automatic wr(input [14:0] x, input [31:0] d, input [3:0] s, input [1:0] e);
      @(posedge clk_sys);
      awa <= {x, 2'b00}; wd <= d; ws <= s; awv <= 1; wv <= 1; bry <= 1;
      do begin
         @(posedge clk_sys);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
      end while (bv !== 1'b1);
      bry <= 0;
      `CHK(bresp, e)
   endtask
   task automatic rd(input [14:0] x, input [7:0] d, input [1:0] e);
      @(posedge clk_sys);
      ara <= {x, 2'b00}; arv <= 1; rry <= 1;
      do begin
         @(posedge clk_sys);
         if (arr) arv <= 0;
      end while (rv !== 1'b1);
      rry <= 0;
      `CHK(rdata, {24'h0, d})
      `CHK(rresp, e)
   endtask
   // shadow keeps only writable bits, so reserved bits must read back zero
   task automatic sw(input int n, input [31:0] d, input [3:0] s);
      wr(ia[n], d, s, `DEP_RESP_OKAY);
      // the reset pulse rises with bvalid, so it still stands at the edge that ends wr
      if (n == 2) `CHK(djr, s[0] && d[7:0] == 8'h00)
      if (s[0]) sh[n] = d[7:0] & ma[n];
   endtask
   task automatic ck;
      for (int j = 0; j < 5; j++) rd(ia[j], sh[j], `DEP_RESP_OKAY);
      `CHK(ov, oexp(sh[0], sh[1], sh[2], sh[3], sh[4]))
   endtask
   task automatic mq(input logic g);
      @(posedge clk_sys) req <= 1;
      @(posedge clk_sys) req <= 0;
      #1 `CHK({gnt, rf}, {g, ~g})
   endtask
   // two frame rises, gap sets their spacing; n is the expected pass count
   task automatic fr(input int gap, input int n);
      int c;
      c = pc;
      repeat (2) begin
         @(posedge clk_sys) pin <= 1;
         repeat (2) @(posedge clk_sys);
         pin <= 0;
         repeat (gap) @(posedge clk_sys);
      end
      repeat (12) @(posedge clk_sys);
      `CHK(pc - c, n)
   endtask
   task close_out;
      if (err_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      ia = '{`DEP_IDX_PAD_DRIVE, `DEP_IDX_MASTER_CLOCK_OUT_PAD_PAD, `DEP_IDX_DEJITTER, `DEP_IDX_EN_MAIN, `DEP_IDX_EN_AUX};
      ma = '{`DEP_MASK_PAD_DRIVE, `DEP_MASK_MASTER_CLOCK_OUT_PAD_PAD, `DEP_MASK_DEJITTER, `DEP_MASK_EN_MAIN, `DEP_MASK_EN_AUX};
      ra = '{`DEP_RST_PAD_DRIVE, `DEP_RST_MASTER_CLOCK_OUT_PAD_PAD, `DEP_RST_DEJITTER, `DEP_RST_EN_MAIN, `DEP_RST_EN_AUX};
      sh = ra;
      repeat (3) @(posedge clk_sys);
      resetn <= 1;
      ck;
      for (k = 0; k < 40; k++) begin
         i = {$random(seed)} % 5;
         sw(i, $random(seed), $random(seed));
         if (k % 8 == 7) ck;
      end
      wr(15'h4033, 32'hff, 4'hf, `DEP_RESP_SLVERR);
      wr(`DEP_IDX_STATUS, 32'hff, 4'hf, `DEP_RESP_SLVERR);
      rd(15'h4033, 8'h00, `DEP_RESP_SLVERR);
      ck;
      sw(3, 8'h41, 1); mq(1);
      sw(3, 8'h40, 1); mq(0);
      sw(3, 8'h01, 1); mq(0);
      sw(3, 8'h30, 1); sw(2, 0, 1); sw(2, 5, 1); fr(1, 1); fr(20, 2);
      sw(2, 0, 1); fr(1, 2);
      sw(2, 5, 1); sw(3, 8'h20, 1); sw(3, 8'h30, 1); fr(20, 0);
      rd(`DEP_IDX_STATUS, 8'h01, `DEP_RESP_OKAY);
      sw(2, 0, 1); sw(2, 5, 1); fr(20, 2);
      sw(2, 0, 1); sw(3, 8'h10, 1); fr(20, 0);
      rd(`DEP_IDX_STATUS, 8'h02, `DEP_RESP_OKAY);
      ck;
      @(posedge clk_sys) resetn <= 0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1;
      sh = ra;
      ck;
      close_out;
   end
endmodule // dep_top_tb
`default_nettype wire
